/* File: hw/btt_decode.sv */
//Function
// - test-under-mask ands destination with source, never writes; z,s from result, v cleared
// - long-address test forms 78 and 79: fetch 4, execute 3, no store
// - trap pushes program counter then flags, loads counter from vector; flags kept
// - exclusive-or writes result back; z,s from result, v cleared, eight forms
// - long-address exclusive-or B8 and B9: fetch 4, execute 3, result stored
// - each flag is kept, taken from result, cleared or left undefined
// - displacement operands are signed 8-bit added to the base address
// - 4-bit working operands sit in the current group; 8-bit ones sit in the page from rp_i[3:0]; 12-bit ones are full addresses
// - suffix-1 fields are destination, suffix-2 fields are source
`timescale 1ns/10ps
`include "btt_regs.svh"
module btt_decode #(
  parameter int unsigned PC_W = 16              // program counter width
) (
  input wire logic sys_clk_i,                   // core clock
  input wire logic rst_i,                       // async reset, active high
  input wire logic ce_i,                        // clock enable, freezes state when low
  input wire logic fetch_valid_i,               // instruction byte offered
  input wire logic [7:0] fetch_byte_i,          // instruction byte
  output logic fetch_ready_o,                   // ready to take the offered byte this cycle
  output logic foreign_op_o,                    // offered opcode belongs elsewhere
  input wire logic [PC_W-1:0] pc_i,             // address after current instruction
  input wire logic [11:0] sp_i,                 // stack pointer
  input wire logic [7:0] rp_i,                  // register pointer
  input wire logic [7:0] flags_i,               // current flags
  output logic [11:0] rda_addr_o,               // destination read address
  input wire logic [7:0] rda_data_i,            // destination read data
  output logic [11:0] rdb_addr_o,               // source read address
  input wire logic [7:0] rdb_data_i,            // source read data
  output logic reg_we_o,                        // register write strobe
  output logic [11:0] reg_waddr_o,              // register write address
  output logic [7:0] reg_wdata_o,               // register write data
  output logic flags_we_o,                      // flags write strobe
  output logic [7:0] flags_o,                   // new flags
  output logic sp_we_o,                         // stack pointer write strobe
  output logic [11:0] sp_o,                     // new stack pointer
  output logic pc_load_o,                       // program counter load strobe
  output logic [PC_W-1:0] pc_o,                 // new program counter
  output logic pmem_rd_o,                       // program memory read
  output logic [PC_W-1:0] pmem_addr_o,          // program memory address
  input wire logic [7:0] pmem_data_i,           // program memory data
  output logic wdt_refresh_o,                   // watchdog refresh pulse
  output logic busy_o,                          // instruction in progress
  output logic done_o                           // last execution cycle
);
  btt_pkg::btt_state_t state_ff;
  logic [7:0] op_ff;
  logic [7:0] opnd_ff [1:3];
  logic [2:0] bcnt_ff;
  logic [2:0] flen_ff;
  logic [2:0] elen_ff;
  logic [2:0] idx_ff;
  logic [7:0] dptr_ff;
  logic [7:0] sptr_ff;
  logic [7:0] vhi_ff;
  logic take;
  logic last_byte;
  logic last_idx;
  logic ptr_phase;
  logic opnd_phase;
  logic is_logic;
  logic is_xor;
  logic is_trap;
  logic is_wdt;
  btt_pkg::btt_kind_t dst_kind;
  btt_pkg::btt_kind_t src_kind;
  logic [11:0] dst_field;
  logic [11:0] src_field;
  logic dst_ind;
  logic src_ind;
  logic [7:0] imm;
  logic [7:0] src_val;
  logic [7:0] result;

  function automatic logic is_logic_op(input logic [7:0] op);
    is_logic_op = (op[7:4] == `BTT_OP_TM_HI || op[7:4] == `BTT_OP_XOR_HI) &&
                  op[3:0] >= `BTT_FORM_RR && op[3:0] <= `BTT_FORM_EIM;
  endfunction : is_logic_op

  function automatic logic in_slice(input logic [7:0] op);
    in_slice = is_logic_op(op) || op == `BTT_OP_TRAP || op == `BTT_OP_WDT;
  endfunction : in_slice

  function automatic logic [2:0] fetch_len(input logic [7:0] op);
    if (op == `BTT_OP_TRAP) fetch_len = `BTT_FETCH_TRAP;
    else if (op == `BTT_OP_WDT) fetch_len = `BTT_FETCH_WDT;
    else if (op[3:0] >= `BTT_FORM_EE) fetch_len = `BTT_FETCH_EXT;
    else if (op[3:0] >= `BTT_FORM_GG) fetch_len = `BTT_FETCH_REG;
    else fetch_len = `BTT_FETCH_WORK;
  endfunction : fetch_len

  function automatic logic [2:0] exec_len(input logic [7:0] op);
    if (op == `BTT_OP_TRAP) exec_len = `BTT_EXEC_TRAP;
    else if (op == `BTT_OP_WDT) exec_len = `BTT_EXEC_WDT;
    else if (op[3:0] >= `BTT_FORM_EE) exec_len = `BTT_EXEC_EXT;
    else if (op[0]) exec_len = `BTT_EXEC_IND;
    else exec_len = `BTT_EXEC_SHORT;
  endfunction : exec_len

  // undefined flags are left as they were, which is one legal outcome
  function automatic logic [7:0] apply_flags(input logic [7:0] old, input logic [7:0] res,
                                             input logic [15:0] act);
    logic [7:0] nf;
    nf = old;
    for (int i = 0; i < 8; i++) begin
      case (btt_pkg::btt_flag_act_t'(act[2*i +: 2]))
        btt_pkg::BTT_ACT_KEEP: nf[i] = old[i];
        btt_pkg::BTT_ACT_CLEAR: nf[i] = 1'b0;
        btt_pkg::BTT_ACT_UNDEF: nf[i] = old[i];
        btt_pkg::BTT_ACT_RESULT: begin
          if (i == `BTT_FLAG_Z) nf[i] = (res == `BTT_RESET_BYTE);
          else if (i == `BTT_FLAG_S) nf[i] = res[7];
          else nf[i] = old[i];
        end
        default: nf[i] = old[i];
      endcase
    end
    apply_flags = nf;
  endfunction : apply_flags

  // foreign opcodes are never acknowledged, so another decoder may take them
  assign fetch_ready_o = (state_ff == btt_pkg::BTT_ST_IDLE && in_slice(fetch_byte_i)) ||
                         state_ff == btt_pkg::BTT_ST_FETCH;
  assign foreign_op_o = state_ff == btt_pkg::BTT_ST_IDLE && fetch_valid_i && !in_slice(fetch_byte_i);
  assign take = ce_i && fetch_valid_i && fetch_ready_o;
  assign last_byte = bcnt_ff == flen_ff - 3'h1;
  assign last_idx = idx_ff == elen_ff - 3'h1;
  assign ptr_phase = idx_ff == elen_ff - 3'h3;
  assign opnd_phase = idx_ff == elen_ff - 3'h2;
  assign is_logic = is_logic_op(op_ff);
  assign is_xor = op_ff[7:4] == `BTT_OP_XOR_HI;
  assign is_trap = op_ff == `BTT_OP_TRAP;
  assign is_wdt = op_ff == `BTT_OP_WDT;
  assign busy_o = state_ff != btt_pkg::BTT_ST_IDLE;

  // suffix 1 fields land on the destination side, suffix 2 on the source side
  always_comb begin
    dst_kind = btt_pkg::BTT_K_REG;
    src_kind = btt_pkg::BTT_K_REG;
    dst_field = {4'h0, opnd_ff[1]};
    src_field = {4'h0, opnd_ff[1]};
    dst_ind = 1'b0;
    src_ind = 1'b0;
    imm = opnd_ff[2];
    case (op_ff[3:0])
      `BTT_FORM_RR, `BTT_FORM_RIR: begin
        dst_kind = btt_pkg::BTT_K_WORK;
        src_kind = btt_pkg::BTT_K_WORK;
        dst_field = {8'h00, opnd_ff[1][7:4]};
        src_field = {8'h00, opnd_ff[1][3:0]};
        src_ind = op_ff[0];
      end
      `BTT_FORM_GG, `BTT_FORM_GIG: begin
        src_field = {4'h0, opnd_ff[1]};
        dst_field = {4'h0, opnd_ff[2]};
        src_ind = op_ff[0];
      end
      `BTT_FORM_GIM, `BTT_FORM_IGIM: begin
        src_kind = btt_pkg::BTT_K_IMM;
        dst_ind = op_ff[0];
      end
      `BTT_FORM_EE: begin
        src_kind = btt_pkg::BTT_K_EXT;
        dst_kind = btt_pkg::BTT_K_EXT;
        src_field = {opnd_ff[1], opnd_ff[2][7:4]};
        dst_field = {opnd_ff[2][3:0], opnd_ff[3]};
      end
      `BTT_FORM_EIM: begin
        src_kind = btt_pkg::BTT_K_IMM;
        dst_kind = btt_pkg::BTT_K_EXT;
        imm = opnd_ff[1];
        dst_field = {opnd_ff[2][3:0], opnd_ff[3]};
      end
      default: begin
        dst_kind = btt_pkg::BTT_K_REG;
      end
    endcase
  end

  // no form of this slice carries a displacement, so both adders see zero
  btt_addr_calc u_dst_addr (
    .rp_i(rp_i),
    .kind_i(dst_kind),
    .field_i(dst_field),
    .use_ptr_i(dst_ind && !ptr_phase),
    .ptr_i(dptr_ff),
    .disp_i(`BTT_RESET_BYTE),
    .addr_o(rda_addr_o)
  );

  btt_addr_calc u_src_addr (
    .rp_i(rp_i),
    .kind_i(src_kind),
    .field_i(src_field),
    .use_ptr_i(src_ind && !ptr_phase),
    .ptr_i(sptr_ff),
    .disp_i(`BTT_RESET_BYTE),
    .addr_o(rdb_addr_o)
  );

  assign src_val = (src_kind == btt_pkg::BTT_K_IMM) ? imm : rdb_data_i;
  assign result = is_xor ? (rda_data_i ^ src_val) : (rda_data_i & src_val);

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= btt_pkg::BTT_ST_IDLE;
      bcnt_ff <= 3'h0;
      idx_ff <= 3'h0;
      flen_ff <= `BTT_FETCH_WDT;
      elen_ff <= `BTT_EXEC_WDT;
      op_ff <= `BTT_RESET_BYTE;
    end else if (ce_i) begin
      case (state_ff)
        btt_pkg::BTT_ST_IDLE: begin
          if (take) begin
            op_ff <= fetch_byte_i;
            flen_ff <= fetch_len(fetch_byte_i);
            elen_ff <= exec_len(fetch_byte_i);
            bcnt_ff <= 3'h1;
            idx_ff <= 3'h0;
            state_ff <= (fetch_len(fetch_byte_i) == `BTT_FETCH_WDT) ? btt_pkg::BTT_ST_EXEC : btt_pkg::BTT_ST_FETCH;
          end
        end
        btt_pkg::BTT_ST_FETCH: begin
          if (take) begin
            bcnt_ff <= bcnt_ff + 3'h1;
            if (last_byte) state_ff <= btt_pkg::BTT_ST_EXEC;
          end
        end
        btt_pkg::BTT_ST_EXEC: begin
          idx_ff <= idx_ff + 3'h1;
          if (last_idx) state_ff <= btt_pkg::BTT_ST_IDLE;
        end
        default: state_ff <= btt_pkg::BTT_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 1; i <= 3; i++) opnd_ff[i] <= `BTT_RESET_BYTE;
    end else if (ce_i && take && state_ff == btt_pkg::BTT_ST_FETCH) begin
      opnd_ff[bcnt_ff[1:0]] <= fetch_byte_i;
    end
  end

  // results are registered one cycle ahead so they show in the last execution cycle
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dptr_ff <= `BTT_RESET_BYTE;
      sptr_ff <= `BTT_RESET_BYTE;
      vhi_ff <= `BTT_RESET_BYTE;
      reg_we_o <= 1'b0;
      reg_waddr_o <= `BTT_RESET_ADDR;
      reg_wdata_o <= `BTT_RESET_BYTE;
      flags_we_o <= 1'b0;
      flags_o <= `BTT_RESET_BYTE;
      sp_we_o <= 1'b0;
      sp_o <= `BTT_RESET_ADDR;
      pc_load_o <= 1'b0;
      pc_o <= PC_W'(`BTT_RESET_PC);
      pmem_rd_o <= 1'b0;
      pmem_addr_o <= PC_W'(`BTT_RESET_PC);
      wdt_refresh_o <= 1'b0;
      done_o <= 1'b0;
    end else if (ce_i) begin
      reg_we_o <= 1'b0;
      flags_we_o <= 1'b0;
      sp_we_o <= 1'b0;
      pc_load_o <= 1'b0;
      pmem_rd_o <= 1'b0;
      wdt_refresh_o <= 1'b0;
      done_o <= 1'b0;
      if (state_ff == btt_pkg::BTT_ST_EXEC && !last_idx) begin
        if (is_logic && ptr_phase) begin
          dptr_ff <= rda_data_i;
          sptr_ff <= rdb_data_i;
        end
        if (is_logic && opnd_phase) begin
          reg_we_o <= is_xor;
          reg_waddr_o <= rda_addr_o;
          reg_wdata_o <= result;
          flags_we_o <= 1'b1;
          flags_o <= apply_flags(flags_i, result, `BTT_LOGIC_FLAG_ACT);
          done_o <= 1'b1;
        end
        if (is_wdt) begin
          wdt_refresh_o <= 1'b1;
          done_o <= 1'b1;
        end
        if (is_trap) begin
          case (idx_ff)
            `BTT_TRAP_STEP_PC_LO: begin
              reg_we_o <= 1'b1;
              reg_waddr_o <= sp_i - `BTT_TRAP_PC_LO_OFS;
              reg_wdata_o <= pc_i[7:0];
            end
            `BTT_TRAP_STEP_PC_HI: begin
              reg_we_o <= 1'b1;
              reg_waddr_o <= sp_i - `BTT_TRAP_PC_HI_OFS;
              reg_wdata_o <= pc_i[15:8];
            end
            `BTT_TRAP_STEP_FLAGS: begin
              reg_we_o <= 1'b1;
              reg_waddr_o <= sp_i - `BTT_TRAP_FLAGS_OFS;
              reg_wdata_o <= flags_i;
              pmem_rd_o <= 1'b1;
              pmem_addr_o <= PC_W'({opnd_ff[1], 1'b0});
            end
            `BTT_TRAP_STEP_VEC_HI: begin
              vhi_ff <= pmem_data_i;
              pmem_rd_o <= 1'b1;
              pmem_addr_o <= PC_W'({opnd_ff[1], 1'b1});
            end
            `BTT_TRAP_STEP_VEC_LO: begin
              pc_load_o <= 1'b1;
              pc_o <= PC_W'({vhi_ff, pmem_data_i});
              sp_we_o <= 1'b1;
              sp_o <= sp_i - `BTT_TRAP_FLAGS_OFS;
              done_o <= 1'b1;
            end
            default: done_o <= 1'b0;
          endcase
        end
      end
    end
  end

endmodule : btt_decode

/* File: common/btt_regs.svh */
`ifndef BTT_REGS_SVH
`define BTT_REGS_SVH

// opcode groups of this slice
`define BTT_OP_TM_HI 4'h7
`define BTT_OP_XOR_HI 4'hb
`define BTT_OP_TRAP 8'hf2
`define BTT_OP_WDT 8'h5f

// low-nibble addressing forms
`define BTT_FORM_RR 4'h2
`define BTT_FORM_RIR 4'h3
`define BTT_FORM_GG 4'h4
`define BTT_FORM_GIG 4'h5
`define BTT_FORM_GIM 4'h6
`define BTT_FORM_IGIM 4'h7
`define BTT_FORM_EE 4'h8
`define BTT_FORM_EIM 4'h9

// fetch cycles (bytes incl. opcode) and execution cycles
`define BTT_FETCH_WORK 3'h2
`define BTT_FETCH_REG 3'h3
`define BTT_FETCH_EXT 3'h4
`define BTT_FETCH_TRAP 3'h2
`define BTT_FETCH_WDT 3'h1
`define BTT_EXEC_SHORT 3'h3
`define BTT_EXEC_IND 3'h4
`define BTT_EXEC_EXT 3'h3
`define BTT_EXEC_TRAP 3'h6
`define BTT_EXEC_WDT 3'h2

// flag bit positions
`define BTT_FLAG_C 7
`define BTT_FLAG_Z 6
`define BTT_FLAG_S 5
`define BTT_FLAG_V 4
`define BTT_FLAG_D 3
`define BTT_FLAG_H 2

// two-bit action per flag, flag n at [2n+1:2n]: c keep, z/s result, v clear, d/h keep
`define BTT_LOGIC_FLAG_ACT 16'h1600

// trap stack offsets below the entry stack pointer
`define BTT_TRAP_PC_LO_OFS 12'h001
`define BTT_TRAP_PC_HI_OFS 12'h002
`define BTT_TRAP_FLAGS_OFS 12'h003

// trap step indices
`define BTT_TRAP_STEP_PC_LO 3'h0
`define BTT_TRAP_STEP_PC_HI 3'h1
`define BTT_TRAP_STEP_FLAGS 3'h2
`define BTT_TRAP_STEP_VEC_HI 3'h3
`define BTT_TRAP_STEP_VEC_LO 3'h4

`define BTT_RESET_BYTE 8'h00
`define BTT_RESET_ADDR 12'h000
`define BTT_RESET_PC 16'h0000

`endif

/* File: common/btt_pkg.sv */
package btt_pkg;

  typedef enum logic [1:0] {
    BTT_ST_IDLE = 2'b00,
    BTT_ST_FETCH = 2'b01,
    BTT_ST_EXEC = 2'b11
  } btt_state_t;

  typedef enum logic [1:0] {
    BTT_K_WORK = 2'h0,
    BTT_K_REG = 2'h1,
    BTT_K_EXT = 2'h2,
    BTT_K_IMM = 2'h3
  } btt_kind_t;

  typedef enum logic [1:0] {
    BTT_ACT_KEEP = 2'h0,
    BTT_ACT_RESULT = 2'h1,
    BTT_ACT_CLEAR = 2'h2,
    BTT_ACT_UNDEF = 2'h3
  } btt_flag_act_t;

endpackage : btt_pkg

/* File: hw/btt_addr_calc.sv */
`timescale 1ns/10ps
module btt_addr_calc (
  input wire logic [7:0] rp_i,                  // register pointer: working group and page
  input wire btt_pkg::btt_kind_t kind_i,        // operand kind
  input wire logic [11:0] field_i,              // raw operand field
  input wire logic use_ptr_i,                   // resolve through fetched pointer
  input wire logic [7:0] ptr_i,                 // pointer register contents
  input wire logic [7:0] disp_i,                // signed displacement, zero when unused
  output logic [11:0] addr_o                    // register file address
);
  logic [11:0] base;

  always_comb begin
    base = field_i;
    if (use_ptr_i) begin
      base = {rp_i[3:0], ptr_i};
    end else begin
      case (kind_i)
        btt_pkg::BTT_K_WORK: base = {rp_i[3:0], rp_i[7:4], field_i[3:0]};
        btt_pkg::BTT_K_REG: base = {rp_i[3:0], field_i[7:0]};
        btt_pkg::BTT_K_EXT: base = field_i;
        default: base = field_i;
      endcase
    end
  end

  // displacement is sign extended before the add
  assign addr_o = base + {{4{disp_i[7]}}, disp_i};

endmodule : btt_addr_calc

/* File: tb/btt_fetch_model.sv */
`timescale 1ns/10ps
module btt_fetch_model #(
  parameter logic [7:0] VEC_HI = 8'hd7,  // vector table high byte
  parameter logic [7:0] VEC_LO = 8'h34   // vector table low byte
) (
  input wire logic sys_clk_i,            // core clock
  input wire logic rst_i,                // async reset
  input wire logic ce_i,                 // clock enable
  input wire logic fetch_ready_i,        // decoder ready to take a byte
  input wire logic pmem_rd_i,            // memory read
  input wire logic [15:0] pmem_addr_i,   // memory address
  output logic fetch_valid_o,            // byte offered
  output logic [7:0] fetch_byte_o,       // instruction byte
  output logic [7:0] pmem_data_o         // memory data
);
  logic [7:0] mem [0:255];
  int head_ff;
  int nxt_head;
  int tail = 0;
  logic slow = 1'b0;
  logic gap_ff;
  logic [7:0] last_ff;
  assign nxt_head = head_ff + int'(ce_i && fetch_valid_o && fetch_ready_i);
  // slow mode leaves every other cycle empty so operand bytes arrive with gaps
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      head_ff <= 0;
      gap_ff <= 1'b0;
      fetch_valid_o <= 1'b0;
      fetch_byte_o <= 8'h00;
    end else begin
      head_ff <= nxt_head;
      gap_ff <= slow && !gap_ff;
      fetch_valid_o <= (nxt_head < tail) && !(slow && !gap_ff);
      // an idle line toggles each cycle between the inverse of the last byte and the byte itself
      fetch_byte_o <= (nxt_head < tail) ? mem[nxt_head] : ~fetch_byte_o;
    end
  end
  assign pmem_data_o = pmem_rd_i ? (pmem_addr_i[0] ? VEC_LO : VEC_HI) : ~last_ff;
  always_ff @(posedge sys_clk_i) begin
    if (pmem_rd_i) begin
      last_ff <= pmem_data_o;
    end
  end
  task push(input logic [7:0] b);
    mem[tail] = b;
    tail = tail + 1;
  endtask : push
  task flush;
    tail = head_ff;
  endtask : flush
endmodule : btt_fetch_model

/* File: tb/btt_decode_assertions.sv */
`timescale 1ns/10ps
module btt_decode_checker #(
  parameter int unsigned PC_W = 16
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic fetch_valid_i,
  input wire logic [7:0] fetch_byte_i,
  input wire logic fetch_ready_o,
  input wire logic foreign_op_o,
  input wire logic [PC_W-1:0] pc_i,
  input wire logic [11:0] sp_i,
  input wire logic [7:0] flags_i,
  input wire logic reg_we_o,
  input wire logic [11:0] reg_waddr_o,
  input wire logic [7:0] reg_wdata_o,
  input wire logic flags_we_o,
  input wire logic [7:0] flags_o,
  input wire logic sp_we_o,
  input wire logic [11:0] sp_o,
  input wire logic pc_load_o,
  input wire logic wdt_refresh_o,
  input wire logic busy_o,
  input wire logic done_o
);
  logic [7:0] op_ff;
  logic [2:0] fcnt_ff;
  logic [2:0] ecnt_ff;
  logic [5:0] len_w;
  logic take;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // {fetch bytes, exec cycles}
  function automatic logic [5:0] lens(input logic [7:0] op);
    if (op == 8'h5f) return 6'h0a;
    if (op == 8'hf2) return 6'h16;
    if (op[3:0] > 4'h7) return 6'h23;
    return {(op[3:0] > 4'h3) ? 3'h3 : 3'h2, op[0] ? 3'h4 : 3'h3};
  endfunction : lens
  assign take = ce_i && fetch_valid_i && fetch_ready_o;
  assign len_w = lens(op_ff);
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      op_ff <= 8'h00;
      fcnt_ff <= 3'h0;
      ecnt_ff <= 3'h0;
    end else if (ce_i) begin
      if (take && !busy_o) begin
        op_ff <= fetch_byte_i;
        fcnt_ff <= 3'h1;
      end else if (take) begin
        fcnt_ff <= fcnt_ff + 3'h1;
      end
      ecnt_ff <= (busy_o && !fetch_ready_o) ? ecnt_ff + 3'h1 : 3'h0;
    end
  end
  sequence trap_push;
    reg_we_o && reg_waddr_o == sp_i - 12'h1 && reg_wdata_o == pc_i[7:0] ##1
    reg_we_o && reg_waddr_o == sp_i - 12'h2 && reg_wdata_o == pc_i[15:8] ##1
    reg_we_o && reg_waddr_o == sp_i - 12'h3 && reg_wdata_o == flags_i;
  endsequence
  a_exec_len: assert property (done_o |-> ecnt_ff == len_w[2:0] - 3'h1 && fcnt_ff == len_w[5:3])
    else $error("fetch or exec length wrong");
  a_done_single: assert property (done_o |=> !done_o && !busy_o)
    else $error("done not a single last cycle");
  a_test_no_store: assert property (busy_o && op_ff[7:4] == 4'h7 |-> !reg_we_o)
    else $error("test op wrote a register");
  a_logic_flags: assert property (flags_we_o && $stable(flags_i) |-> done_o && !flags_o[4]
    && flags_o[7] == flags_i[7] && flags_o[3:2] == flags_i[3:2])
    else $error("kept or cleared flag wrong");
  a_xor_result: assert property (reg_we_o && op_ff[7:4] == 4'hb |-> flags_we_o
    && flags_o[6] == (reg_wdata_o == 8'h00) && flags_o[5] == reg_wdata_o[7])
    else $error("xor zero or sign flag wrong");
  a_trap_seq: assert property ($rose(reg_we_o) && op_ff == 8'hf2 |-> trap_push ##2
    pc_load_o && sp_we_o && sp_o == sp_i - 12'h3 && done_o)
    else $error("trap push sequence wrong");
  a_trap_flags: assert property (busy_o && (op_ff == 8'hf2 || op_ff == 8'h5f) |-> !flags_we_o)
    else $error("trap or refresh wrote flags");
  a_wdt_timing: assert property (take && !busy_o && fetch_byte_i == 8'h5f |-> ##2 wdt_refresh_o && done_o)
    else $error("refresh pulse misplaced");
  a_foreign_held: assert property (foreign_op_o |-> !fetch_ready_o ##1 !busy_o)
    else $error("foreign opcode was taken");
endmodule : btt_decode_checker
bind btt_decode btt_decode_checker #(.PC_W(PC_W)) chk_u (.sys_clk_i, .rst_i, .ce_i, .fetch_valid_i,
  .fetch_byte_i, .fetch_ready_o, .foreign_op_o, .pc_i, .sp_i, .flags_i, .reg_we_o, .reg_waddr_o,
  .reg_wdata_o, .flags_we_o, .flags_o, .sp_we_o, .sp_o, .pc_load_o, .wdt_refresh_o, .busy_o, .done_o);

/* File: tb/test_bitwise_test_trap_decode.sv */
`timescale 1ns/10ps
module test_bitwise_test_trap_decode;
  logic sys_clk_i, rst_i, ce_i, fetch_valid_i, fetch_ready_o, foreign_op_o, reg_we_o, flags_we_o;
  logic sp_we_o, pc_load_o, pmem_rd_o, wdt_refresh_o, busy_o, done_o;
  logic [7:0] fetch_byte_i, rp_i, flags_i, rda_data_i, rdb_data_i, reg_wdata_o, flags_o, pmem_data_i;
  logic [11:0] sp_i, rda_addr_o, rdb_addr_o, reg_waddr_o, sp_o;
  logic [15:0] pc_i, pc_o, pmem_addr_o, pc_got, sp_got;
  logic [7:0] rf [0:4095];
  logic [15:0] wr_a [0:3];
  logic [7:0] wr_d [0:3];
  logic [7:0] fl_got;
  int num_errors = 0, total_checks = 0, n_wr, n_fl, n_pc, n_wdt, i;
  assign rda_data_i = rf[rda_addr_o];
  assign rdb_data_i = rf[rdb_addr_o];
  btt_decode #(.PC_W(16)) dut_u (.sys_clk_i, .rst_i, .ce_i, .fetch_valid_i, .fetch_byte_i, .fetch_ready_o,
    .foreign_op_o, .pc_i, .sp_i, .rp_i, .flags_i, .rda_addr_o, .rda_data_i, .rdb_addr_o, .rdb_data_i,
    .reg_we_o, .reg_waddr_o, .reg_wdata_o, .flags_we_o, .flags_o, .sp_we_o, .sp_o, .pc_load_o, .pc_o,
    .pmem_rd_o, .pmem_addr_o, .pmem_data_i, .wdt_refresh_o, .busy_o, .done_o);
  btt_fetch_model partner_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i), .fetch_ready_i(fetch_ready_o),
    .pmem_rd_i(pmem_rd_o), .pmem_addr_i(pmem_addr_o), .fetch_valid_o(fetch_valid_i),
    .fetch_byte_o(fetch_byte_i), .pmem_data_o(pmem_data_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    if (reg_we_o) begin
      if (n_wr < 4) wr_a[n_wr] = {4'h0, reg_waddr_o};
      if (n_wr < 4) wr_d[n_wr] = reg_wdata_o;
      rf[reg_waddr_o] = reg_wdata_o;
      n_wr++;
    end
    if (flags_we_o) fl_got = flags_o;
    n_fl += int'(flags_we_o);
    if (pc_load_o && sp_we_o) {pc_got, sp_got} = {pc_o, 4'h0, sp_o};
    n_pc += int'(pc_load_o && sp_we_o);
    n_wdt += int'(wdt_refresh_o);
  end
  task chk_v(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_v
  task chk_n(input int got, input int exp);
    chk_v(got[15:0], exp[15:0]);
  endtask : chk_n
  task stop_test;
    $display("errors=%0d checks=%0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  task automatic run(input logic [7:0] op, b1, b2, b3, input int nb);
    int k;
    @(negedge sys_clk_i);
    {n_wr, n_fl, n_pc, n_wdt} = '0;
    partner_u.push(op);
    if (nb > 0) partner_u.push(b1);
    if (nb > 1) partner_u.push(b2);
    if (nb > 2) partner_u.push(b3);
    for (k = 0; k < 60 && done_o !== 1'b1; k++) @(negedge sys_clk_i);
    if (k == 60) begin
      num_errors++;
      stop_test();
    end
    @(posedge sys_clk_i);
    #1;
  endtask : run
  // model of each short and long form: destination, source, then the flag image
  task automatic logic_op(input logic [7:0] op, b1, b2, b3);
    logic [11:0] da, sa;
    logic [7:0] s, r;
    int nb;
    case (op[3:0])
      4'h2, 4'h3: {da, sa, nb} = {rp_i[3:0], rp_i[7:4], b1[7:4], rp_i[3:0], rp_i[7:4], b1[3:0], 32'd1};
      4'h4, 4'h5: {sa, da, nb} = {rp_i[3:0], b1, rp_i[3:0], b2, 32'd2};
      4'h6, 4'h7: {da, sa, nb} = {rp_i[3:0], b1, 12'h000, 32'd2};
      default: {sa, da, nb} = {b1, b2[7:4], b2[3:0], b3, 32'd3};
    endcase
    if (op[0] && op[3:0] < 4'h6) sa = {rp_i[3:0], rf[sa]};
    if (op[3:0] == 4'h7) da = {rp_i[3:0], rf[da]};
    s = (op[3:0] == 4'h6 || op[3:0] == 4'h7) ? b2 : ((op[3:0] == 4'h9) ? b1 : rf[sa]);
    r = (op[7:4] == 4'hb) ? (rf[da] ^ s) : (rf[da] & s);
    run(op, b1, b2, b3, nb);
    chk_n(n_fl, 1);
    chk_v({8'h00, fl_got}, {8'h00, (flags_i & 8'h8f) | {1'b0, r == 8'h00, r[7], 5'h00}});
    chk_n(n_wr, int'(op[7:4] == 4'hb));
    if (op[7:4] == 4'hb) chk_v(wr_a[0], {4'h0, da});
    if (op[7:4] == 4'hb) chk_v({8'h00, wr_d[0]}, {8'h00, r});
  endtask : logic_op
  task automatic trap_then_refresh;
    run(8'hf2, 8'h12, 8'h00, 8'h00, 1);
    chk_n(n_wr, 3);
    chk_v(wr_a[0], {4'h0, sp_i - 12'h1});
    chk_v(wr_a[2], {4'h0, sp_i - 12'h3});
    chk_v({wr_d[1], wr_d[0]}, pc_i);
    chk_v({8'h00, wr_d[2]}, {8'h00, flags_i});
    chk_n(n_fl, 0);
    chk_n(n_pc, 1);
    chk_v(pc_got, 16'hd734);
    chk_v(sp_got, {4'h0, sp_i - 12'h3});
    run(8'h5f, 8'h00, 8'h00, 8'h00, 0);
    chk_n(n_wdt, 1);
    chk_n(n_fl + n_wr, 0);
  endtask : trap_then_refresh
  task automatic foreign_refused;
    @(negedge sys_clk_i);
    partner_u.push(8'h62);
    repeat (4) @(negedge sys_clk_i);
    chk_v({15'h0, foreign_op_o}, 16'h0001);
    chk_v({15'h0, busy_o}, 16'h0000);
    partner_u.flush();
    @(negedge sys_clk_i);
  endtask : foreign_refused
  // with the clock enable low an offered opcode must not be taken
  task automatic ce_frozen;
    @(posedge sys_clk_i);
    ce_i <= 1'b0;
    n_wdt = 0;
    partner_u.push(8'h5f);
    repeat (4) @(posedge sys_clk_i);
    #1;
    chk_v({15'h0, busy_o}, 16'h0000);
    chk_n(n_wdt, 0);
    partner_u.flush();
    @(posedge sys_clk_i);
    ce_i <= 1'b1;
    @(posedge sys_clk_i);
  endtask : ce_frozen
  initial begin
    {rst_i, ce_i, rp_i, flags_i, sp_i, pc_i} = {2'b11, 8'h21, 8'h9e, 12'h200, 16'hbeef};
    for (i = 0; i < 4096; i++) rf[i] = i[7:0] ^ {i[11:8], 4'h5};
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    foreign_refused();
    ce_frozen();
    for (i = 0; i < 16; i++) begin
      partner_u.slow = i[0];
      logic_op({(i < 8) ? 4'h7 : 4'hb, 4'h2 + {1'b0, i[2:0]}}, 8'h35, 8'h4b, 8'hcd);
    end
    partner_u.slow = 1'b0;
    logic_op(8'hb2, 8'h44, 8'h00, 8'h00);
    trap_then_refresh();
    stop_test();
  end
endmodule : test_bitwise_test_trap_decode
